/* pkg/nfc_pkg.sv */
// Constants, types and command table for the NOR flash host controller
package nfc_pkg;

  // ----------------------------------------------------------------
  // Register map of the controller
  // ----------------------------------------------------------------
  localparam logic [7:0]  NFC_REG_CTRL    = 8'h00;
  localparam logic [7:0]  NFC_REG_ADDR    = 8'h04;
  localparam logic [7:0]  NFC_REG_WDATA   = 8'h08;
  localparam logic [7:0]  NFC_REG_RDATA   = 8'h0C;
  localparam logic [7:0]  NFC_REG_STAT    = 8'h10;
  localparam int unsigned CTRL_VPP_BIT    = 4;
  localparam int unsigned CTRL_CFG_BIT    = 5;
  localparam logic        CTRL_VPP_RST    = 1'b0;
  localparam logic        CFG_RST         = 1'b0;

  // ----------------------------------------------------------------
  // Status word bit positions
  // ----------------------------------------------------------------
  localparam int unsigned POLL_STATUS_BIT   = 7;
  localparam int unsigned TOGGLE_STATUS_BIT = 6;
  localparam int unsigned OP_FAIL_BIT       = 5;
  localparam int unsigned SUPPLY_LOW_BIT    = 3;
  localparam int unsigned AUX_STATUS_BIT    = 2;
  localparam logic [15:0] ERASED_WORD       = 16'hFFFF;

  // ----------------------------------------------------------------
  // Command cycles, upper data lanes always zero
  // ----------------------------------------------------------------
  localparam logic [19:0] CMD_ADDR_1   = 20'h00555;
  localparam logic [19:0] CMD_ADDR_2   = 20'h002AA;
  localparam logic [15:0] CMD_DATA_1   = 16'h00AA;
  localparam logic [15:0] CMD_DATA_2   = 16'h0055;
  localparam logic [15:0] CMD_PROG     = 16'h00A0;
  localparam logic [15:0] CMD_ERASE    = 16'h0080;
  localparam logic [15:0] CMD_CHIP     = 16'h0010;
  localparam logic [15:0] CMD_SECTOR   = 16'h0030;
  localparam logic [15:0] CMD_CFG      = 16'h00D0;
  localparam logic [15:0] ID_MODE_EXIT_CMD = 16'h00F0;

  // ----------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------
  localparam int unsigned CLK_PERIOD_NS  = 100;
  localparam int unsigned RST_LOW_NS     = 500;
  localparam int unsigned RST_REC_NS     = 1000;
  localparam logic [3:0]  RST_LOW_CYC    = 4'((RST_LOW_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
  localparam logic [3:0]  RST_REC_CYC    = 4'((RST_REC_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);

  typedef enum logic [2:0] {
    OP_NONE   = 3'h0,
    OP_READ   = 3'h1,
    OP_PROG   = 3'h2,
    OP_SERASE = 3'h3,
    OP_CERASE = 3'h4,
    OP_CFG    = 3'h5,
    OP_EXIT   = 3'h6,
    OP_RESET  = 3'h7
  } nfc_op_t;

  typedef struct packed {
    logic [19:0] addr;
    logic [15:0] data;
  } nfc_bus_t;

  // Number of bus cycles of a command sequence
  function automatic logic [2:0] cmdLen(input nfc_op_t op);
    case (op)
      OP_PROG, OP_CFG:      cmdLen = 3'h4;
      OP_SERASE, OP_CERASE: cmdLen = 3'h6;
      default:              cmdLen = 3'h1;
    endcase
  endfunction

  // Address and data of cycle idx of a command sequence
  function automatic nfc_bus_t cmdCycle(input nfc_op_t op, input logic [2:0] idx,
                                        input logic [19:0] a, input logic [15:0] d, input logic cfg);
    nfc_bus_t b;
    b.addr = CMD_ADDR_1;
    b.data = CMD_DATA_1;
    if (op == OP_EXIT) begin
      b.addr = a;
      b.data = ID_MODE_EXIT_CMD;
    end else begin
      case (idx)
        3'h1, 3'h4: begin
          b.addr = CMD_ADDR_2;
          b.data = CMD_DATA_2;
        end
        3'h2: b.data = (op == OP_PROG) ? CMD_PROG : (op == OP_CFG) ? CMD_CFG : CMD_ERASE;
        3'h3: begin
          if (op != OP_SERASE && op != OP_CERASE) begin
            b.addr = a;
            b.data = (op == OP_PROG) ? d : {15'h0000, cfg};
          end
        end
        3'h5: begin
          b.addr = (op == OP_SERASE) ? a : CMD_ADDR_1;
          b.data = (op == OP_SERASE) ? CMD_SECTOR : CMD_CHIP;
        end
        default: b.data = CMD_DATA_1;
      endcase
    end
    return b;
  endfunction

endpackage

/* hdl/nfc_host.sv */
// Host controller that drives a 16-bit NOR flash through its pins
`timescale 1ns/1ns

// Contract
// - write pulses strobe with select low, gate high
// - address at later fall, data at earlier rise
// - six-cycle sector erase, code 30H last
// - any failure needs exit command; a poll timeout sets failFlag and timeout but sends none
module nfc_host
  import nfc_pkg::*;
#(
  parameter logic [23:0] POLL_MAX_READS = 24'hFFFFFF
) (
  input  wire logic        core_clk,
  input  wire logic        rst_n,
  input  wire logic [7:0]  regAddr,
  input  wire logic [31:0] regWdata,
  input  wire logic        regWr,
  input  wire logic        regRd,
  output logic      [31:0] regRdata,
  output logic      [19:0] flashAddr,
  output logic             flashCeN,
  output logic             flashOeN,
  output logic             flashWeN,
  output logic             flashRstN,
  output logic             vppEnable,
  output logic      [15:0] dataOut,
  output logic             dataOe,
  input  wire logic [15:0] dataIn
);

  // ----------------------------------------------------------------
  // Sequencer states
  // ----------------------------------------------------------------
  typedef enum logic [3:0] {
    ST_IDLE   = 4'h0,
    ST_WLOAD  = 4'h1,
    ST_WSET   = 4'h2,
    ST_WLOW   = 4'h3,
    ST_WHIGH  = 4'h4,
    ST_WEND   = 4'h5,
    ST_RACT   = 4'h6,
    ST_RGAP   = 4'h7,
    ST_RSTLOW = 4'h8,
    ST_RSTREC = 4'h9
  } nfc_state_t;

  nfc_state_t  state;
  nfc_op_t     seqOp;
  nfc_op_t     ctrlOp;
  nfc_bus_t    bus;
  logic [2:0]  idx;
  logic [3:0]  cnt;
  logic [23:0] pollCount;
  logic [19:0] addrReg;
  logic [15:0] wdataReg;
  logic [15:0] rdWord;
  logic [15:0] lastStatus;
  logic [15:0] expectWord;
  logic        goReg;
  logic        abortReg;
  logic        cfgArg;
  logic        cfgReg;
  logic        polling;
  logic        firstRead;
  logic        prevToggle;
  logic        busy;
  logic        done;
  logic        failFlag;
  logic        opFail;
  logic        supplyLow;
  logic        timeout;
  logic        stopped;
  logic        failNow;

  // ----------------------------------------------------------------
  // Software registers
  // ----------------------------------------------------------------
  // Orders are taken only while idle; a reset order is taken at any time
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      goReg     <= 1'b0;
      abortReg  <= 1'b0;
      ctrlOp    <= OP_NONE;
      vppEnable <= CTRL_VPP_RST;
      cfgArg    <= CFG_RST;
      addrReg   <= 20'h00000;
      wdataReg  <= 16'h0000;
    end else begin
      goReg    <= 1'b0;
      abortReg <= 1'b0;
      if (regWr && regAddr == NFC_REG_CTRL) begin
        vppEnable <= regWdata[CTRL_VPP_BIT];
        if (nfc_op_t'(regWdata[2:0]) == OP_RESET) begin
          abortReg <= 1'b1;
        end else if (regWdata[2:0] != 3'h0 && !busy && !goReg) begin
          goReg  <= 1'b1;
          ctrlOp <= nfc_op_t'(regWdata[2:0]);
          cfgArg <= regWdata[CTRL_CFG_BIT];
        end
      end
      if (regWr && regAddr == NFC_REG_ADDR && !busy) begin
        addrReg <= regWdata[19:0];
      end
      if (regWr && regAddr == NFC_REG_WDATA && !busy) begin
        wdataReg <= regWdata[15:0];
      end
    end
  end

  // Read data stand one cycle after the read strobe
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      regRdata <= 32'h00000000;
    end else if (regRd) begin
      case (regAddr)
        NFC_REG_CTRL:  regRdata <= {26'h0000000, cfgArg, vppEnable, 1'b0, ctrlOp};
        NFC_REG_ADDR:  regRdata <= {12'h000, addrReg};
        NFC_REG_WDATA: regRdata <= {16'h0000, wdataReg};
        NFC_REG_RDATA: regRdata <= {16'h0000, rdWord};
        NFC_REG_STAT:  regRdata <= {lastStatus, 9'h000, timeout, cfgReg, supplyLow, opFail, failFlag, done, busy};
        default:       regRdata <= 32'h00000000;
      endcase
    end else begin
      regRdata <= 32'h00000000;
    end
  end

  // ----------------------------------------------------------------
  // Poll decisions
  // ----------------------------------------------------------------
  // Current command cycle and the word a finished operation must show
  always_comb begin
    bus        = cmdCycle(seqOp, idx, addrReg, wdataReg, cfgArg);
    expectWord = (seqOp == OP_PROG) ? wdataReg : ERASED_WORD;
    stopped    = !firstRead && (rdWord[TOGGLE_STATUS_BIT] == prevToggle);
    if (cfgReg) begin
      failNow = rdWord[OP_FAIL_BIT] | rdWord[SUPPLY_LOW_BIT] | !rdWord[POLL_STATUS_BIT];
    end else begin
      failNow = (rdWord != expectWord);
    end
  end

  // ----------------------------------------------------------------
  // Pin sequencer
  // ----------------------------------------------------------------
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      state      <= ST_IDLE;
      seqOp      <= OP_NONE;
      idx        <= 3'h0;
      cnt        <= 4'h0;
      pollCount  <= 24'h000000;
      flashAddr  <= 20'h00000;
      flashCeN   <= 1'b1;
      flashOeN   <= 1'b1;
      flashWeN   <= 1'b1;
      flashRstN  <= 1'b1;
      dataOut    <= 16'h0000;
      dataOe     <= 1'b0;
      rdWord     <= 16'h0000;
      lastStatus <= 16'h0000;
      polling    <= 1'b0;
      firstRead  <= 1'b0;
      prevToggle <= 1'b0;
      busy       <= 1'b0;
      done       <= 1'b0;
      failFlag   <= 1'b0;
      opFail     <= 1'b0;
      supplyLow  <= 1'b0;
      timeout    <= 1'b0;
      cfgReg     <= CFG_RST;
    end else if (abortReg) begin
      flashCeN  <= 1'b1;
      flashOeN  <= 1'b1;
      flashWeN  <= 1'b1;
      dataOe    <= 1'b0;
      flashRstN <= 1'b0;
      cnt       <= 4'h0;
      polling   <= 1'b0;
      busy      <= 1'b1;
      done      <= 1'b0;
      state     <= ST_RSTLOW;
    end else begin
      case (state)
        ST_IDLE: begin
          if (goReg) begin
            busy      <= 1'b1;
            done      <= 1'b0;
            failFlag  <= 1'b0;
            opFail    <= 1'b0;
            supplyLow <= 1'b0;
            timeout   <= 1'b0;
            seqOp     <= ctrlOp;
            idx       <= 3'h0;
            polling   <= 1'b0;
            if (ctrlOp == OP_READ) begin
              flashAddr <= addrReg;
              flashCeN  <= 1'b0;
              flashOeN  <= 1'b0;
              state     <= ST_RACT;
            end else begin
              state <= ST_WLOAD;
            end
          end
        end
        ST_WLOAD: begin
          flashAddr <= bus.addr;
          dataOut   <= bus.data;
          dataOe    <= 1'b1;
          flashCeN  <= 1'b0;
          state     <= ST_WSET;
        end
        ST_WSET: begin
          flashWeN <= 1'b0;
          state    <= ST_WLOW;
        end
        ST_WLOW: begin
          flashWeN <= 1'b1;
          state    <= ST_WHIGH;
        end
        ST_WHIGH: begin
          flashCeN <= 1'b1;
          dataOe   <= 1'b0;
          state    <= ST_WEND;
        end
        ST_WEND: begin
          if (idx != cmdLen(seqOp) - 3'h1) begin
            idx   <= idx + 3'h1;
            state <= ST_WLOAD;
          end else if (seqOp == OP_EXIT || seqOp == OP_CFG) begin
            if (seqOp == OP_CFG) begin
              cfgReg <= cfgArg;
            end
            busy  <= 1'b0;
            done  <= 1'b1;
            state <= ST_IDLE;
          end else begin
            polling   <= 1'b1;
            firstRead <= 1'b1;
            pollCount <= 24'h000000;
            flashAddr <= addrReg;
            flashCeN  <= 1'b0;
            flashOeN  <= 1'b0;
            state     <= ST_RACT;
          end
        end
        ST_RACT: begin
          rdWord   <= dataIn;
          flashCeN <= 1'b1;
          flashOeN <= 1'b1;
          state    <= ST_RGAP;
        end
        ST_RGAP: begin
          if (!polling) begin
            busy  <= 1'b0;
            done  <= 1'b1;
            state <= ST_IDLE;
          end else begin
            lastStatus <= rdWord;
            firstRead  <= 1'b0;
            prevToggle <= rdWord[TOGGLE_STATUS_BIT];
            pollCount  <= pollCount + 24'h000001;
            if (stopped && (failNow || cfgReg)) begin
              failFlag  <= failNow;
              opFail    <= failNow & rdWord[OP_FAIL_BIT];
              supplyLow <= failNow & rdWord[SUPPLY_LOW_BIT];
              polling   <= 1'b0;
              seqOp     <= OP_EXIT;
              idx       <= 3'h0;
              state     <= ST_WLOAD;
            end else if (stopped) begin
              polling <= 1'b0;
              busy    <= 1'b0;
              done    <= 1'b1;
              state   <= ST_IDLE;
            end else if (pollCount == POLL_MAX_READS) begin
              polling  <= 1'b0;
              timeout  <= 1'b1;
              failFlag <= 1'b1;
              busy     <= 1'b0;
              done     <= 1'b1;
              state    <= ST_IDLE;
            end else begin
              flashCeN <= 1'b0;
              flashOeN <= 1'b0;
              state    <= ST_RACT;
            end
          end
        end
        ST_RSTLOW: begin
          cnt <= cnt + 4'h1;
          if (cnt == RST_LOW_CYC - 4'h1) begin
            flashRstN <= 1'b1;
            cnt       <= 4'h0;
            state     <= ST_RSTREC;
          end
        end
        ST_RSTREC: begin
          cnt <= cnt + 4'h1;
          if (cnt == RST_REC_CYC - 4'h1) begin
            busy  <= 1'b0;
            done  <= 1'b1;
            state <= ST_IDLE;
          end
        end
        default: state <= ST_IDLE;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  oe_during_write_a: assert property (@(posedge core_clk) disable iff (!rst_n) !flashWeN |-> flashOeN)
    else $error("output gate low during write strobe");
  we_in_select_a: assert property (@(posedge core_clk) disable iff (!rst_n) !flashWeN |-> (!flashCeN && dataOe))
    else $error("write strobe without select or data");
  read_strobe_a: assert property (@(posedge core_clk) disable iff (!rst_n) !flashOeN |-> (flashWeN && !dataOe))
    else $error("read overlaps write or data drive");
  data_latch_a: assert property (@(posedge core_clk) disable iff (!rst_n)
    $rose(flashWeN) |-> ($stable(dataOut) && $stable(flashAddr) && dataOe && !flashCeN))
    else $error("data or address moved before latch edge");
  reset_width_a: assert property (@(posedge core_clk) disable iff (!rst_n)
    $fell(flashRstN) |-> !flashRstN [*5])
    else $error("flash reset pulse too short");
  cfg_keep_a: assert property (@(posedge core_clk) disable iff (!rst_n) !flashRstN |=> $stable(cfgReg))
    else $error("config changed by flash reset");
  poll_quiet_a: assert property (@(posedge core_clk) disable iff (!rst_n) polling |-> flashWeN)
    else $error("command written while operation busy");
  fail_exit_a: assert property (@(posedge core_clk) disable iff (!rst_n)
    (state == ST_RGAP && polling && stopped && failNow) |=> (seqOp == OP_EXIT && failFlag) ##2 !flashWeN)
    else $error("failure not followed by exit command");
  cfg_exit_a: assert property (@(posedge core_clk) disable iff (!rst_n)
    (state == ST_RGAP && polling && stopped && cfgReg) |=> (seqOp == OP_EXIT && busy))
    else $error("config 01 success without exit command");
  upper_lane_a: assert property (@(posedge core_clk) disable iff (!rst_n)
    (dataOe && !(seqOp == OP_PROG && idx == 3'h3)) |-> dataOut[15:8] == 8'h00)
    else $error("command cycle drives upper data lanes");

endmodule

/* test/nfc_flash_model.sv */
// Behavioural model of the 16-bit NOR flash on the far side of the host controller
`timescale 1ns/1ns
module nfc_flash_model
  import nfc_pkg::*;
#(
  parameter int          PROG_NS  = 3000,
  parameter int          ERASE_NS = 8000,
  parameter logic [4:0]  LOCKED   = 5'h03,
  parameter logic [15:0] PRESET   = 16'h1234
) (
  input  wire logic [19:0] flashAddr,
  input  wire logic        flashCeN,
  input  wire logic        flashOeN,
  input  wire logic        flashWeN,
  input  wire logic        flashRstN,
  input  wire logic        vppEnable,
  input  wire logic [15:0] dataOut,
  input  wire logic        dataOe,
  output logic      [15:0] dq,
  output logic             busRuleErr
);
  logic [15:0] mem [logic [19:0]];
  logic [15:0] outWord, opData, busWord;
  logic [19:0] wrAddr, opAddr;
  logic [2:0]  seqPos;
  logic [7:0]  seqCode;
  logic        cfgReg, busy, statusMode, isErase, failBit, lowBit, toggle;
  time         busyEnd;
  wire         wrLow = !flashCeN && !flashWeN;
  wire         rdLow = !flashCeN && !flashOeN && flashWeN;

  // Released bus shows the inverse of the last word, never a stale copy
  assign dq = (rdLow && flashRstN) ? outWord : ~outWord;

  // Power-up state: read mode, config 00, one preset word in the locked sector
  initial begin
    mem[{LOCKED, 15'h0000}] = PRESET;
    cfgReg     = 1'b0;
    busy       = 1'b0;
    statusMode = 1'b0;
    seqPos     = 3'h0;
    toggle     = 1'b0;
    outWord    = 16'h0000;
    busRuleErr = 1'b0;
  end

  // Starts a self-timed program or erase, or refuses it at once
  task automatic startOp(input logic erase, input logic chip);
    logic locked;
    locked     = !chip && (wrAddr[19:15] == LOCKED);
    isErase    = erase;
    opAddr     = wrAddr;
    toggle     = 1'b0;
    lowBit     = !vppEnable;
    failBit    = locked;
    statusMode = lowBit || locked;
    if (!statusMode) begin
      busy    = 1'b1;
      busyEnd = $time + (erase ? ERASE_NS : PROG_NS);
      if (!erase) begin
        mem[wrAddr] = (mem.exists(wrAddr) ? mem[wrAddr] : ERASED_WORD) & opData;
      end else begin
        foreach (mem[k]) begin
          if (chip ? (k[19:15] != LOCKED) : (k[19:15] == wrAddr[19:15])) mem[k] = ERASED_WORD;
        end
      end
    end
  endtask

  // Command sequencer on the low byte of each written word
  task automatic decode(input logic [15:0] w);
    logic [7:0] c;
    c = w[7:0];
    case (seqPos)
      3'h0: begin
        if (c == ID_MODE_EXIT_CMD[7:0]) statusMode = 1'b0;
        seqPos = (c == CMD_DATA_1[7:0]) ? 3'h1 : 3'h0;
      end
      3'h1: seqPos = (c == CMD_DATA_2[7:0]) ? 3'h2 : 3'h0;
      3'h2: begin
        seqCode = c;
        seqPos  = (c == CMD_PROG[7:0] || c == CMD_CFG[7:0] || c == CMD_ERASE[7:0]) ? 3'h3 : 3'h0;
      end
      3'h3: begin
        seqPos = 3'h0;
        if (seqCode == CMD_PROG[7:0]) begin
          opData = w;
          startOp(1'b0, 1'b0);
        end else if (seqCode == CMD_CFG[7:0]) begin
          cfgReg = w[0];
        end else if (c == CMD_DATA_1[7:0]) begin
          seqPos = 3'h4;
        end
      end
      3'h4: seqPos = (c == CMD_DATA_2[7:0]) ? 3'h5 : 3'h0;
      default: begin
        seqPos = 3'h0;
        if (c == CMD_SECTOR[7:0]) startOp(1'b1, 1'b0);
        else if (c == CMD_CHIP[7:0]) startOp(1'b1, 1'b1);
      end
    endcase
  endtask

  // Address taken when both strobes are low, data at the first rise
  always @(posedge wrLow) begin
    if (flashRstN) wrAddr = flashAddr;
  end

  always @(negedge wrLow) begin
    busWord = dataOe ? dataOut : ~dataOut;
    if (flashRstN && flashOeN === 1'b0) busRuleErr = 1'b1;
    if (flashRstN && !busy) decode(busWord);
  end

  // Each read reports status while busy, after a failure or after any finished operation in config 01, else the stored word
  always @(posedge rdLow) begin
    if (flashRstN) begin
      if (busy && $time >= busyEnd) begin
        busy       = 1'b0;
        statusMode = cfgReg;
      end
      if (busy) begin
        toggle  = ~toggle;
        outWord = {8'h00, (!cfgReg && !isErase && flashAddr == opAddr) ? ~opData[7] : 1'b0, toggle, 6'h00};
      end else if (statusMode) begin
        outWord = {8'h00, 1'b1, toggle, failBit, 1'b0, lowBit, 3'h0};
      end else begin
        outWord = mem.exists(flashAddr) ? mem[flashAddr] : ERASED_WORD;
      end
    end
  end

  // Reset aborts, corrupts a word under programming, keeps the config
  always @(negedge flashRstN) begin
    if (busy && !isErase) mem[opAddr] = opData ^ 16'hA5A5;
    busy       = 1'b0;
    statusMode = 1'b0;
    seqPos     = 3'h0;
  end
endmodule

/* test/nfc_host_tb.sv */
// Self-checking bench for the NOR flash host controller
`timescale 1ns/1ns
module nfc_host_tb;
  import nfc_pkg::*;
  typedef struct packed {
    logic [31:0] exp;
    logic [31:0] mask;
  } nfc_note_t;
  localparam logic [31:0] STAT_MASK  = 32'h0000007F;
  localparam int          MAX_CYCLES = 20000;
  logic        core_clk, rst_n, regWr, regRd, flashCeN, flashOeN, flashWeN, flashRstN;
  logic        vppEnable, dataOe, busRuleErr, vppOn, cfgVal, rdSeen;
  logic [7:0]  regAddr;
  logic [31:0] regWdata, regRdata;
  logic [19:0] flashAddr, addrA, addrB, addrL;
  logic [15:0] dataOut, dataIn, wordA, wordB;
  integer      seed;
  int          fails, num_checks, cycles;
  nfc_note_t   notes[$];
  nfc_note_t   curNote;

  nfc_host #(.POLL_MAX_READS(24'h000040)) u_dut (
    .core_clk(core_clk), .rst_n(rst_n), .regAddr(regAddr), .regWdata(regWdata), .regWr(regWr),
    .regRd(regRd), .regRdata(regRdata), .flashAddr(flashAddr), .flashCeN(flashCeN), .flashOeN(flashOeN),
    .flashWeN(flashWeN), .flashRstN(flashRstN), .vppEnable(vppEnable), .dataOut(dataOut), .dataOe(dataOe),
    .dataIn(dataIn)
  );
  nfc_flash_model u_flash (
    .flashAddr(flashAddr), .flashCeN(flashCeN), .flashOeN(flashOeN), .flashWeN(flashWeN),
    .flashRstN(flashRstN), .vppEnable(vppEnable), .dataOut(dataOut), .dataOe(dataOe), .dq(dataIn),
    .busRuleErr(busRuleErr)
  );

  // Clock
  initial core_clk = 1'b0;
  always #50 core_clk = ~core_clk;

  // Compares one value under a mask
  task automatic checkWord(input string name, input logic [31:0] e, input logic [31:0] m, input logic [31:0] got);
    num_checks++;
    if ((got & m) !== (e & m)) begin
      fails++;
      $display("unexpected %s: expected %h seen %h", name, e & m, got & m);
    end
  endtask

  task automatic tally_and_finish();
    if (fails == 0 && num_checks > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask

  // Watcher: read data stands the cycle after the strobe, oldest note first
  always @(posedge core_clk) begin
    rdSeen <= regRd;
    if (rdSeen && notes.size() > 0) begin
      curNote = notes.pop_front();
      if (curNote.mask != 32'h00000000) checkWord("regRdata", curNote.exp, curNote.mask, regRdata);
    end
  end

  // Hang guard
  always @(posedge core_clk) begin
    cycles++;
    if (cycles == MAX_CYCLES) begin
      fails++;
      tally_and_finish();
    end
  end

  // Register bus cycles
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge core_clk);
    regAddr  <= a;
    regWdata <= d;
    regWr    <= 1'b1;
    @(posedge core_clk);
    regWr    <= 1'b0;
  endtask

  task automatic rd(input logic [7:0] a, input logic [31:0] e, input logic [31:0] m);
    @(posedge core_clk);
    notes.push_back('{exp: e, mask: m});
    regAddr <= a;
    regRd   <= 1'b1;
    @(posedge core_clk);
    regRd   <= 1'b0;
  endtask

  // Status word of a finished operation
  function automatic logic [31:0] st(input logic f, input logic o, input logic l);
    st = {25'h0000000, 1'b0, cfgVal, l, o, f, 1'b1, 1'b0};
  endfunction

  // Starts an operation, polls busy, then checks the status flags
  task automatic runOp(input logic [2:0] op, input logic [19:0] a, input logic [15:0] d, input logic [31:0] e);
    wr(NFC_REG_ADDR, {12'h000, a});
    wr(NFC_REG_WDATA, {16'h0000, d});
    wr(NFC_REG_CTRL, {26'h0000000, cfgVal, vppOn, 1'b0, op});
    for (int i = 0; i < 300; i++) begin
      rd(NFC_REG_STAT, 32'h00000000, 32'h00000000);
      #1;
      if (regRdata[0] !== 1'b1) break;
    end
    rd(NFC_REG_STAT, e, STAT_MASK);
  endtask

  task automatic readWord(input logic [19:0] a, input logic [15:0] e);
    runOp(3'h1, a, 16'h0000, st(1'b0, 1'b0, 1'b0));
    rd(NFC_REG_RDATA, {16'h0000, e}, 32'h0000FFFF);
  endtask

  // Main sequence
  initial begin
    seed = 32'h973C3C65;
    rst_n = 1'b0;
    regWr = 1'b0;
    regRd = 1'b0;
    regAddr = 8'h00;
    regWdata = 32'h00000000;
    vppOn = 1'b1;
    cfgVal = 1'b0;
    fails = 0;
    num_checks = 0;
    addrA = {5'h01, 15'($random(seed))};
    addrB = {5'h02, 15'($random(seed))};
    addrL = {5'h03, 15'h0000};
    wordA = 16'($random(seed)) & 16'hFFFE;
    wordB = 16'($random(seed)) & 16'hFF5F;
    repeat (10) @(posedge core_clk);
    rst_n <= 1'b1;
    rd(NFC_REG_STAT, 32'h00000000, STAT_MASK);
    rd(8'h20, 32'h00000000, 32'hFFFFFFFF);
    runOp(3'h2, addrA, wordA, st(1'b0, 1'b0, 1'b0));
    readWord(addrA, wordA);
    runOp(3'h2, addrA, ~wordA, st(1'b1, 1'b0, 1'b0));
    readWord(addrA, 16'h0000);
    runOp(3'h3, addrA, 16'h0000, st(1'b0, 1'b0, 1'b0));
    readWord(addrA, ERASED_WORD);
    vppOn = 1'b0;
    runOp(3'h2, addrB, wordB, st(1'b1, 1'b0, 1'b1));
    readWord(addrB, ERASED_WORD);
    vppOn = 1'b1;
    runOp(3'h2, addrL, wordB, st(1'b1, 1'b1, 1'b0));
    runOp(3'h3, addrL, 16'h0000, st(1'b1, 1'b1, 1'b0));
    cfgVal = 1'b1;
    runOp(3'h5, addrB, 16'h0000, st(1'b0, 1'b0, 1'b0));
    runOp(3'h2, addrB, wordB, st(1'b0, 1'b0, 1'b0));
    readWord(addrB, wordB);
    runOp(3'h6, addrB, 16'h0000, st(1'b0, 1'b0, 1'b0));
    runOp(3'h7, 20'h00000, 16'h0000, st(1'b0, 1'b0, 1'b0));
    runOp(3'h2, addrA, wordB, st(1'b0, 1'b0, 1'b0));
    cfgVal = 1'b0;
    runOp(3'h5, addrB, 16'h0000, st(1'b0, 1'b0, 1'b0));
    runOp(3'h4, addrB, 16'h0000, st(1'b0, 1'b0, 1'b0));
    readWord(addrB, ERASED_WORD);
    readWord(addrL, 16'h1234);
    // Let the watcher compare the last read before the verdict
    repeat (2) @(posedge core_clk);
    checkWord("busRuleErr", 32'h00000000, 32'h00000001, {31'h00000000, busRuleErr});
    tally_and_finish();
  end
endmodule
